/* File: core/sirl_pkg.sv */
// Shared constants for the safety input and restart interlock block
package sirl_pkg;

  // ****************************************************************
  // Register map (byte addresses, one 32-bit word each)
  // ****************************************************************
  localparam logic [7:0] SIRL_ADDR_CTRL     = 8'h00; // Mode and interlock enables
  localparam logic [7:0] SIRL_ADDR_STATUS   = 8'h04; // Live state, read only
  localparam logic [7:0] SIRL_ADDR_IRQ_STAT = 8'h08; // Sticky events, write one to clear
  localparam logic [7:0] SIRL_ADDR_IRQ_MASK = 8'h0C; // Interrupt enables

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SIRL_CTRL_MODE_BIT   = 0;  // 0 complementary, 1 one-of-n
  localparam int SIRL_CTRL_ILK_LSB    = 8;  // One interlock enable per output
  localparam int SIRL_STAT_CASE_LSB   = 8;  // Two-bit monitoring case index
  localparam int SIRL_STAT_VALID_BIT  = 10; // Monitoring case is valid
  localparam int SIRL_STAT_DECERR_BIT = 12; // Input pattern invalid
  localparam int SIRL_STAT_LNKERR_BIT = 13; // Transmission fault present
  localparam int SIRL_STAT_CHAN_LSB   = 16; // Raw synchronised channels

  // Interrupt event bits
  localparam int SIRL_EV_DECERR  = 0; // Invalid input pattern appeared
  localparam int SIRL_EV_LNKERR  = 1; // Transmission fault appeared
  localparam int SIRL_EV_TRIP    = 2; // Some output went off
  localparam int SIRL_EV_RELEASE = 3; // A reset released an output
  localparam int SIRL_EV_W       = 4; // Number of event bits

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic        SIRL_RST_MODE    = 1'b0; // Complementary after reset
  localparam logic        SIRL_RST_ILK     = 1'b1; // Interlock on after reset
  localparam logic [31:0] SIRL_RST_WORD    = 32'h0000_0000;
  localparam logic [3:0]  SIRL_RST_EVENTS  = 4'h0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint SIRL_CLK_HZ      = 100_000_000; // Core clock rate
  localparam longint SIRL_MIN_OFF_MS  = 80;          // Least off time after trip
  localparam longint SIRL_MIN_OFF_CYC = (SIRL_MIN_OFF_MS * SIRL_CLK_HZ + 999) / 1000;

  // Evaluation modes
  localparam logic SIRL_MODE_COMPL = 1'b0;
  localparam logic SIRL_MODE_ONEN  = 1'b1;

  // Per-output interlock states
  typedef enum logic [2:0]
  {
    SIRL_ST_ON     = 3'b001, // Output on, field clear
    SIRL_ST_TIMED  = 3'b010, // Least off time running
    SIRL_ST_LOCKED = 3'b100  // Waiting for a reset or interlock disable
  } sirl_state_type;

endpackage : sirl_pkg

/* File: core/sirl_output_channel.sv */
// One safety output with least off time and restart interlock
`timescale 1ns/1ns
module sirl_output_channel
  import sirl_pkg::*;
#(
  parameter int CNT_W   = 23,
  parameter int OFF_CYC = 8_000_000
)
(
  // Clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  // Conditions
  input  wire logic i_field_clear,  // Protective field free
  input  wire logic i_fault,        // Any error forces off
  input  wire logic i_ilk_en,       // Restart interlock enabled
  input  wire logic i_reset_ok,     // Accepted reset pulse
  // Results
  output logic      o_on,           // Safety output state
  output logic      o_trip,         // Pulse: output just went off
  output logic      o_release       // Pulse: reset released output
);

  // ****************************************************************
  // State
  // ****************************************************************
  sirl_state_type   state_q, state_d;   // Interlock state
  logic [CNT_W-1:0] cnt_q, cnt_d;       // Off time counter
  logic             trip_q, trip_d;     // Trip pulse
  logic             rel_q, rel_d;       // Release pulse
  wire  logic       trip_now;           // Field broken or fault
  wire  logic       cnt_done;           // Off time over

  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(OFF_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // RULE14 fault drops output
  assign trip_now = ~i_field_clear | i_fault;
  assign cnt_done = (cnt_q == CNT_ZERO);

  // Next state
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    trip_d  = 1'b0;
    rel_d   = 1'b0;
    if (trip_now)
    begin
      // RULE6 reload off time
      state_d = SIRL_ST_TIMED;
      cnt_d   = CNT_LOAD;
      trip_d  = (state_q == SIRL_ST_ON);
    end
    else
    begin
      case (state_q)
        SIRL_ST_ON:
        begin
          state_d = SIRL_ST_ON;
        end
        SIRL_ST_TIMED:
        begin
          // RULE6 hold off full time
          if (cnt_done)
          begin
            // RULE9 latch off when enabled
            state_d = i_ilk_en ? SIRL_ST_LOCKED : SIRL_ST_ON;
          end
          else
          begin
            cnt_d = cnt_q - CNT_ONE;
          end
        end
        SIRL_ST_LOCKED:
        begin
          // RULE10 release on clear field
          if (i_reset_ok | ~i_ilk_en)
          begin
            state_d = SIRL_ST_ON;
            rel_d   = i_reset_ok;
          end
        end
        default:
        begin
          state_d = SIRL_ST_LOCKED;
        end
      endcase
    end
  end

  // Registers; start-up enters the locked state
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      // RULE11 start-up interlock
      state_q <= SIRL_ST_LOCKED;
      cnt_q   <= CNT_ZERO;
      trip_q  <= 1'b0;
      rel_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      trip_q  <= trip_d;
      rel_q   <= rel_d;
    end
  end

  assign o_on      = (state_q == SIRL_ST_ON);
  assign o_trip    = trip_q;
  assign o_release = rel_q;

endmodule : sirl_output_channel

/* File: core/sirl_top.sv */
// Static input decoding, restart interlock and APB registers
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ns

// Overview of operation
// RULE1: Complementary pair: 10 is 0, 01 is 1
// RULE2: Equal channels in complementary mode are errors
// RULE3: Non-inverted pair forces all outputs off
// RULE4: One-of-n needs exactly one channel high
// RULE5: Single high channel one..four selects case
// RULE6: Trip keeps output off at least 80 ms
// RULE7: Each output has configurable restart interlock
// RULE8: Reset request arrives as network signal
// RULE9: Interlocked output stays off after field clears
// RULE10: Reset releases only with field clear
// RULE11: Reset also clears start-up interlock
// RULE12: Resets ignored while any fault present
// RULE13: Controller needs separate start after reset
// RULE14: Faulty transmission forces outputs off
// RULE15: Long network expectation needs interlock enabled
// RULE16: Reset acts only on its rising edge
module sirl_top
  import sirl_pkg::*;
#(
  parameter int     NUM_OUT = 2,                // Safety outputs
  parameter longint OFF_CYC = SIRL_MIN_OFF_CYC  // Least off time in cycles
)
(
  // Clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_srst,
  // APB slave
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [7:0]         i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic [31:0]             o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  // Network input channels
  input  wire logic               i_pair_a_first_channel,
  input  wire logic               i_pair_a_second_channel,
  input  wire logic               i_pair_b_first_channel,
  input  wire logic               i_pair_b_second_channel,
  // Field, reset request and link health
  input  wire logic [NUM_OUT-1:0] i_field_clear,
  input  wire logic               i_reset_req,
  input  wire logic               i_link_fault,
  // Results
  output logic [NUM_OUT-1:0]      o_safe_out,
  output logic [1:0]              o_case,
  output logic                    o_case_valid,
  output logic                    o_error,
  output logic                    o_irq
);

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // One-hot of four channels to case index
  function automatic logic [1:0] sirl_onehot_idx(input logic [3:0] v);
    logic [1:0] idx;
    idx = 2'h0;
    if (v[1])
      idx = 2'h1;
    else if (v[2])
      idx = 2'h2;
    else if (v[3])
      idx = 2'h3;
    return idx;
  endfunction : sirl_onehot_idx

  localparam int CNT_W = $clog2(OFF_CYC + 1);
  localparam int SY_W  = 6 + NUM_OUT;  // Four channels, fields, reset, fault

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [SY_W-1:0]    sy1_q;      // First stage, read only by sy2_q
  logic [SY_W-1:0]    sy2_q;      // Second stage, safe to use
  logic               rreq_q;     // Previous reset request level
  wire  logic [SY_W-1:0] sy_in;   // Gathered raw pins

  assign sy_in = {i_link_fault, i_reset_req, i_field_clear,
                  i_pair_b_second_channel, i_pair_b_first_channel,
                  i_pair_a_second_channel, i_pair_a_first_channel};

  // Two flops before use; pins come from the network interface
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      sy1_q  <= '0;
      sy2_q  <= '0;
      rreq_q <= 1'b0;
    end
    else
    begin
      sy1_q  <= sy_in;
      sy2_q  <= sy1_q;
      rreq_q <= sy2_q[NUM_OUT+4];
    end
  end

  wire logic [3:0]         chan     = sy2_q[3:0];          // Pair a first channel in bit 0
  wire logic [NUM_OUT-1:0] fld_clr  = sy2_q[NUM_OUT+3:4];
  wire logic               rreq     = sy2_q[NUM_OUT+4];
  wire logic               lnk_err  = sy2_q[NUM_OUT+5];

  // ****************************************************************
  // Control and interrupt registers
  // ****************************************************************
  logic               mode_q;     // Evaluation method
  logic [NUM_OUT-1:0] ilk_en_q;   // Interlock enables
  logic [SIRL_EV_W-1:0] irq_stat_q;
  logic [SIRL_EV_W-1:0] irq_mask_q;

  // ****************************************************************
  // Input decoding
  // ****************************************************************
  // RULE1 pair value is second channel
  wire logic a_val = chan[1];
  wire logic b_val = chan[3];
  // RULE2 equal channels flag error
  wire logic a_bad = ~(chan[0] ^ chan[1]);
  wire logic b_bad = ~(chan[2] ^ chan[3]);
  // RULE4 exactly one channel high
  wire logic onen_ok = (chan == 4'h1) | (chan == 4'h2) | (chan == 4'h4) | (chan == 4'h8);

  // RULE3 any pair counts, used or not
  wire logic dec_err = (mode_q == SIRL_MODE_COMPL) ? (a_bad | b_bad) : ~onen_ok;
  // RULE5 single channel selects case
  wire logic [1:0] case_d = (mode_q == SIRL_MODE_ONEN) ? sirl_onehot_idx(chan) : {b_val, a_val};
  // RULE14 link fault joins errors
  wire logic any_err = dec_err | lnk_err;

  // RULE16 act on rising edge only
  wire logic rreq_rise = rreq & ~rreq_q;
  // RULE12 ignore reset during faults
  // RULE8 reset taken from network pin
  wire logic reset_ok = rreq_rise & ~any_err;

  // ****************************************************************
  // Output channels
  // ****************************************************************
  wire logic [NUM_OUT-1:0] out_on;    // Channel states
  wire logic [NUM_OUT-1:0] out_trip;  // Trip pulses
  wire logic [NUM_OUT-1:0] out_rel;   // Release pulses

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_out
      // RULE7 own interlock per output
      sirl_output_channel #(
        .CNT_W   (CNT_W),
        .OFF_CYC (int'(OFF_CYC))
      ) u_chan (
        .i_core_clk    (i_core_clk),
        .i_srst        (i_srst),
        .i_field_clear (fld_clr[g]),
        .i_fault       (any_err),
        .i_ilk_en      (ilk_en_q[g]),
        .i_reset_ok    (reset_ok),
        .o_on          (out_on[g]),
        .o_trip        (out_trip[g]),
        .o_release     (out_rel[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Events
  // ****************************************************************
  logic dec_err_q;   // Previous decode error
  logic lnk_err_q;   // Previous link fault
  wire  logic [SIRL_EV_W-1:0] ev;

  assign ev[SIRL_EV_DECERR]  = dec_err & ~dec_err_q;
  assign ev[SIRL_EV_LNKERR]  = lnk_err & ~lnk_err_q;
  assign ev[SIRL_EV_TRIP]    = |out_trip;
  assign ev[SIRL_EV_RELEASE] = |out_rel;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire logic setup   = i_psel & ~i_penable;
  wire logic access  = i_psel & i_penable & o_pready;
  wire logic hit_ctl = (i_paddr == SIRL_ADDR_CTRL);
  wire logic hit_sts = (i_paddr == SIRL_ADDR_STATUS);
  wire logic hit_ist = (i_paddr == SIRL_ADDR_IRQ_STAT);
  wire logic hit_msk = (i_paddr == SIRL_ADDR_IRQ_MASK);
  wire logic mapped  = hit_ctl | hit_sts | hit_ist | hit_msk;
  // Status is read only, so writing it errors
  wire logic bad_acc = ~mapped | (hit_sts & i_pwrite);
  wire logic wr_ok   = access & i_pwrite & ~o_pslverr;

  wire logic [31:0] ctrl_word = (32'(mode_q) << SIRL_CTRL_MODE_BIT)
                              | (32'(ilk_en_q) << SIRL_CTRL_ILK_LSB);
  wire logic [31:0] stat_word = 32'(out_on)
                              | (32'(o_case) << SIRL_STAT_CASE_LSB)
                              | (32'(o_case_valid) << SIRL_STAT_VALID_BIT)
                              | (32'(dec_err) << SIRL_STAT_DECERR_BIT)
                              | (32'(lnk_err) << SIRL_STAT_LNKERR_BIT)
                              | (32'(chan) << SIRL_STAT_CHAN_LSB);
  wire logic [31:0] rd_word;

  assign rd_word = hit_ctl ? ctrl_word :
                   hit_sts ? stat_word :
                   hit_ist ? 32'(irq_stat_q) :
                   hit_msk ? 32'(irq_mask_q) : SIRL_RST_WORD;

  // Read data and answer are latched in setup so outputs come from flops
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_prdata  <= SIRL_RST_WORD;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
    else if (setup)
    begin
      o_prdata  <= i_pwrite ? SIRL_RST_WORD : rd_word;
      o_pready  <= 1'b1;
      o_pslverr <= bad_acc;
    end
    else
    begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // ****************************************************************
  // Registers written by software
  // ****************************************************************
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      mode_q     <= SIRL_RST_MODE;
      ilk_en_q   <= {NUM_OUT{SIRL_RST_ILK}};
      irq_mask_q <= SIRL_RST_EVENTS;
    end
    else if (wr_ok & hit_ctl)
    begin
      mode_q   <= i_pwdata[SIRL_CTRL_MODE_BIT];
      ilk_en_q <= i_pwdata[SIRL_CTRL_ILK_LSB +: NUM_OUT];
    end
    else if (wr_ok & hit_msk)
    begin
      irq_mask_q <= i_pwdata[SIRL_EV_W-1:0];
    end
  end

  // Sticky events; a new event beats a clear in the same cycle
  wire logic [SIRL_EV_W-1:0] w1c = (wr_ok & hit_ist) ? i_pwdata[SIRL_EV_W-1:0] : SIRL_RST_EVENTS;

  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      irq_stat_q <= SIRL_RST_EVENTS;
      // Cleared synchronisers read as an invalid pattern; no false event
      dec_err_q  <= 1'b1;
      lnk_err_q  <= 1'b0;
      o_irq      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~w1c) | ev;
      dec_err_q  <= dec_err;
      lnk_err_q  <= lnk_err;
      o_irq      <= |(((irq_stat_q & ~w1c) | ev) & irq_mask_q);
    end
  end

  // ****************************************************************
  // Result outputs
  // ****************************************************************
  // Outputs re-registered; one cycle behind channel state
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      o_safe_out   <= '0;
      o_case       <= 2'h0;
      o_case_valid <= 1'b0;
      o_error      <= 1'b0;
    end
    else
    begin
      // RULE3 error gates every output
      o_safe_out   <= out_on & {NUM_OUT{~any_err}};
      o_case       <= case_d;
      o_case_valid <= ~dec_err;
      o_error      <= any_err;
    end
  end

endmodule : sirl_top

/* File: dv/sirl_asserts.sv */
// Port checks for the input decode and restart interlock block
`timescale 1ns/1ns
module sirl_asserts
  import sirl_pkg::*;
#(
  parameter int     NUM_OUT = 2,
  parameter longint OFF_CYC = 20
)
(
  // Clock, reset and bus
  input wire logic               i_core_clk,
  input wire logic               i_srst,
  input wire logic               i_psel,
  input wire logic               i_penable,
  input wire logic               i_pwrite,
  input wire logic [7:0]         i_paddr,
  input wire logic               o_pready,
  input wire logic               o_pslverr,
  // Inputs and results
  input wire logic               i_pair_a_first_channel,
  input wire logic               i_pair_a_second_channel,
  input wire logic [NUM_OUT-1:0] i_field_clear,
  input wire logic               i_link_fault,
  input wire logic [NUM_OUT-1:0] o_safe_out,
  input wire logic               o_case_valid,
  input wire logic               o_error
);
  // ****************
  // Helper logic
  // ****************
  logic [31:0] off_cnt_q; // Off cycles of output 0, saturating
  logic [31:0] off_cnt_d;
  logic        bad_addr;  // Refused address or direction
  assign bad_addr = (i_paddr > SIRL_ADDR_IRQ_MASK) || (i_paddr[1:0] != 2'h0)
                    || (i_pwrite && i_paddr == SIRL_ADDR_STATUS);
  assign off_cnt_d = o_safe_out[0] ? 32'h0 : ((off_cnt_q < 32'(OFF_CYC)) ? off_cnt_q + 32'h1 : off_cnt_q);
  // Full after reset, since start-up release owes no off time
  always_ff @(posedge i_core_clk)
  begin
    off_cnt_q <= i_srst ? 32'(OFF_CYC) : off_cnt_d;
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  AST_PREADY_NEXT: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready after setup");
  AST_PREADY_ONE: assert property (o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  AST_BAD_ADDR: assert property (i_psel && !i_penable && bad_addr |=> o_pslverr)
    else $error("refused access without error");
  AST_EQUAL_PAIR: assert property ((i_pair_a_first_channel && i_pair_a_second_channel) [*5] |-> !o_case_valid && o_error)
    else $error("equal pair decoded as valid");
  AST_ERR_OFF: assert property (o_error [*2] |-> o_safe_out == '0)
    else $error("output on during error");
  AST_LINK_OFF: assert property (i_link_fault [*5] |-> o_error && o_safe_out == '0)
    else $error("link fault tolerated");
  AST_MIN_OFF: assert property ($rose(o_safe_out[0]) |-> off_cnt_q >= 32'(OFF_CYC))
    else $error("off time too short");
  AST_RISE_CLEAR: assert property ($rose(o_safe_out[0]) |-> $past(i_field_clear[0], 4) && !o_error)
    else $error("output on with field busy or error");
  CV_RELEASE: cover property ($rose(o_safe_out[0]));
  CV_TRIP: cover property ($fell(o_safe_out[1]));
  CV_REFUSED: cover property (o_pready && o_pslverr);
endmodule : sirl_asserts

bind sirl_top sirl_asserts #(.NUM_OUT(NUM_OUT), .OFF_CYC(OFF_CYC)) u_asserts (
  .i_core_clk(i_core_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_pair_a_first_channel(i_pair_a_first_channel), .i_pair_a_second_channel(i_pair_a_second_channel),
  .i_field_clear(i_field_clear), .i_link_fault(i_link_fault), .o_safe_out(o_safe_out),
  .o_case_valid(o_case_valid), .o_error(o_error));

/* File: dv/sirl_ctrl_model.sv */
// Behavioural network controller feeding channels and reset requests
`timescale 1ns/1ns
module sirl_ctrl_model
(
  // Clock, commands from the bench and device output states
  input  wire logic       i_core_clk,
  input  wire logic [3:0] i_pattern,  // Wanted pair levels, pair a first in bit 0
  input  wire logic       i_pulse,    // Ask for one reset pulse
  input  wire logic       i_hold,     // Keep the request high
  input  wire logic [1:0] i_safe_out,
  // Towards the device
  output logic            o_pair_a_first_channel,
  output logic            o_pair_a_second_channel,
  output logic            o_pair_b_first_channel,
  output logic            o_pair_b_second_channel,
  output logic            o_reset_req,
  output logic            o_start     // Separate start command
);
  logic [1:0] pulse_q = 2'h0; // Pulse cycles left
  logic [1:0] on_q    = 2'h0; // Output states last cycle
  // Channels and pulse leave just after the edge
  always_ff @(posedge i_core_clk)
  begin
    {o_pair_b_second_channel, o_pair_b_first_channel, o_pair_a_second_channel, o_pair_a_first_channel} <= i_pattern;
    pulse_q <= i_pulse ? 2'h3 : ((pulse_q != 2'h0) ? pulse_q - 2'h1 : 2'h0);
    on_q    <= i_safe_out;
    // start only once an output came back
    o_start <= |(i_safe_out & ~on_q);
  end
  // reset travels as a network level
  assign o_reset_req = i_hold || (pulse_q != 2'h0);
endmodule : sirl_ctrl_model

/* File: dv/tb_safety_input_restart_interlock.sv */
// Self-checking bench for the input decode and restart interlock block
`timescale 1ns/1ns
module tb_safety_input_restart_interlock
  import sirl_pkg::*;
;
  localparam longint OFF = 20; // Shortened least off time
  logic clk, srst, psel, penable, pwrite, pready, pslverr, req, link, valid, err, irq, pulse, hold;
  logic a_fst, a_snd, b_fst, b_snd; // Pair channels from the controller model
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  field, safe, case_o;
  logic [3:0]  pattern;
  logic [32:0] exq[$]; // Expected {pslverr, prdata} per transfer
  int fail_count, checks_done, cyc;

  sirl_top #(.NUM_OUT(2), .OFF_CYC(OFF)) dut (
    .i_core_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pair_a_first_channel(a_fst), .i_pair_a_second_channel(a_snd), .i_pair_b_first_channel(b_fst),
    .i_pair_b_second_channel(b_snd), .i_field_clear(field), .i_reset_req(req), .i_link_fault(link),
    .o_safe_out(safe), .o_case(case_o), .o_case_valid(valid), .o_error(err), .o_irq(irq));
  sirl_ctrl_model u_ctrl (
    .i_core_clk(clk), .i_pattern(pattern), .i_pulse(pulse), .i_hold(hold), .i_safe_out(safe),
    .o_pair_a_first_channel(a_fst), .o_pair_a_second_channel(a_snd), .o_pair_b_first_channel(b_fst),
    .o_pair_b_second_channel(b_snd), .o_reset_req(req), .o_start());

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task chk(input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test

  // One transfer; request held until ready is sampled
  // No local limit; a stuck transfer is ended by the hang guard
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    exq.push_back(e);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask : apb

  task pulse_rst;
    @(posedge clk);
    pulse <= 1'b1;
    @(posedge clk);
    pulse <= 1'b0;
    repeat (12) @(posedge clk);
  endtask : pulse_rst

  // Bus results compared against the oldest note
  always @(posedge clk)
  begin
    if (psel && penable && pready === 1'b1)
      chk({pslverr, prdata}, exq.pop_front());
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      fail_count++;
      stop_test();
    end
  end

  initial
  begin
    logic [3:0] p, r;
    logic       v;
    logic [1:0] cs;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pattern, pulse, hold, field, link, srst} = {4'h6, 1'b0, 1'b0, 2'b11, 1'b0, 1'b1};
    r = 4'($urandom(31241));
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, SIRL_ADDR_CTRL, 32'h0, 33'h0_0000_0300);
    apb(1'b0, SIRL_ADDR_IRQ_MASK, 32'h0, 33'h0);
    apb(1'b0, 8'h10, 32'h0, 33'h1_0000_0000);
    apb(1'b1, SIRL_ADDR_STATUS, 32'hFFFF_FFFF, 33'h1_0000_0000);
    $display("register test done");
    chk(33'(safe), 33'h0);
    link <= 1'b1;
    repeat (8) @(posedge clk);
    hold <= 1'b1;
    repeat (8) @(posedge clk);
    chk(33'({safe, err}), 33'h1);
    link <= 1'b0;
    repeat (OFF + 10) @(posedge clk);
    chk(33'(safe), 33'h0);
    hold <= 1'b0;
    pulse_rst();
    chk(33'(safe), 33'h3);
    $display("release test done");
    apb(1'b1, SIRL_ADDR_IRQ_STAT, 32'hF, 33'h0);
    apb(1'b1, SIRL_ADDR_IRQ_MASK, 32'h4, 33'h0);
    field <= 2'b10;
    @(posedge clk);
    field <= 2'b11;
    repeat (OFF + 20) @(posedge clk);
    chk(33'({safe, irq}), 33'h5);
    field <= 2'b10;
    repeat (6) @(posedge clk);
    pulse_rst();
    chk(33'(safe), 33'h2);
    field <= 2'b11;
    repeat (OFF + 10) @(posedge clk);
    pulse_rst();
    chk(33'(safe), 33'h3);
    apb(1'b0, SIRL_ADDR_IRQ_STAT, 32'h0, 33'h0_0000_000C);
    apb(1'b1, SIRL_ADDR_IRQ_STAT, 32'hC, 33'h0);
    repeat (3) @(posedge clk);
    chk(33'(irq), 33'h0);
    $display("trip test done");
    // Output 0 restarts by itself once its lock is off
    apb(1'b1, SIRL_ADDR_CTRL, 32'h200, 33'h0);
    field <= 2'b10;
    @(posedge clk);
    field <= 2'b11;
    repeat (OFF - 2) @(posedge clk);
    chk(33'(safe), 33'h2);
    repeat (20) @(posedge clk);
    chk(33'(safe), 33'h3);
    $display("auto restart test done");
    // Every channel pattern in both modes, shuffled order
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, SIRL_ADDR_CTRL, 32'h300 | 32'(m), 33'h0);
      for (int k = 0; k < 16; k++)
      begin
        p = 4'(k) ^ r;
        pattern <= p;
        repeat (8) @(posedge clk);
        v = (m == 1) ? ($countones(p) == 1) : ((p[0] ^ p[1]) && (p[2] ^ p[3]));
        cs = (m == 1) ? {p[3] | p[2], p[3] | p[1]} : {p[3], p[1]};
        chk(33'({valid, err}), 33'({v, !v}));
        if (v)
          chk(33'(case_o), 33'(cs));
        else
          chk(33'(safe), 33'h0);
      end
    end
    $display("decode test done");
    chk(33'(exq.size()), 33'h0);
    stop_test();
  end
endmodule : tb_safety_input_restart_interlock
